// ---- shared/tap_defs.svh ----
// Constants for the boundary scan test access port
// Notes on behaviour
// - Bypass, identification and boundary scan data registers; one selected at a time.
// - Bypass is the default path when no other data register is needed.
// - Identification register is 32 bits: marker bit, identity, part, version.
// - Boundary scan register captures every pin and can drive every pin.
// - Three chained scan cells per pin, each with serial in/out and parallel in; only the output and enable cells have parallel out.
// - Controller is a 16-state machine in a 4-bit encoding.
// - State changes only on rising TCK, steered by TMS sampled there, apart from TRST.
// - Instruction states work the instruction register; data states the selected data register.
// - Controller derives capture, shift, update and clock controls from TMS and TCK.
// - Controller starts in Test-Logic-Reset at power-up; the code has no power-up reset for state_reg, only TRST puts it there.
// - Five rising TCK edges with TMS high reach Test-Logic-Reset from anywhere.
// - TRST forces Test-Logic-Reset at once, without TCK.
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

`define BS_PINS        8
`define BS_CELLS       3
`define BS_LEN         (`BS_PINS * `BS_CELLS)
`define IR_LEN         4
`define IR_CAPTURE     4'h1
`define INS_EXTEST     4'h0
`define INS_SAMPLE     4'h1
`define INS_IDCODE     4'he
`define INS_BYPASS     4'hf
`define ID_LEN         32
// Identity fields: values arbitrary
`define ID_VERSION     4'h1
`define ID_PART        16'h0123
`define ID_MAKER       11'h055
`define CELL_IN        0
`define CELL_OUT       1
`define CELL_OE        2
`define STREAM_DEPTH   32

`endif

// ---- shared/tap_pkg.sv ----
// Types for the boundary scan test access port
`include "tap_defs.svh"

package tap_pkg;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic [`BS_PINS-1:0] oe;
    logic [`BS_PINS-1:0] out;
  } pin_drive_t;

  typedef struct packed {
    logic [3:0]  version;
    logic [15:0] part;
    logic [10:0] maker;
    logic        marker;
  } id_word_t;

endpackage : tap_pkg

// ---- hw/scan_fifo.sv ----
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module scan_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] rd_data_reg;
  logic             rd_valid_reg;

  wire logic full   = (count_reg == (AW+1)'(DEPTH));
  wire logic empty  = (count_reg == '0);
  wire logic push   = in_valid_i && !full;
  wire logic load   = !rd_valid_reg || out_ready_i;
  wire logic pop    = load && !empty;

  assign in_ready_o  = !full;
  assign out_data_o  = rd_data_reg;
  assign out_valid_o = rd_valid_reg;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      if (load)
        rd_valid_reg <= !empty;
      if (pop)
        rd_data_reg <= mem_reg[rd_ptr_reg];
    end
  end

endmodule : scan_fifo

`default_nettype wire

// ---- hw/boundary_scan_tap.sv ----
// Test access port with instruction, bypass, identification and boundary scan registers
`timescale 1ns/1ps
`default_nettype none
`include "tap_defs.svh"

module boundary_scan_tap
  import tap_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                tck_i,
  input  wire logic                trst_n_i,
  input  wire logic                tms_i,
  input  wire logic                tdi_i,
  output logic                     tdo_o,
  output logic                     tdo_oe_o,
  input  wire logic [`BS_PINS-1:0] pin_in_i,
  input  wire logic [`BS_PINS-1:0] core_out_i,
  input  wire logic [`BS_PINS-1:0] core_oe_i,
  output logic      [`BS_PINS-1:0] test_out_o,
  output logic      [`BS_PINS-1:0] test_oe_o,
  output logic                     extest_o,
  output logic      [3:0]          tap_state_o,
  output pin_drive_t               upd_data_o,
  output logic                     upd_valid_o,
  input  wire logic                upd_ready_i
);

  localparam id_word_t ID_WORD = '{version: `ID_VERSION, part: `ID_PART,
                                   maker: `ID_MAKER, marker: 1'b1};

  // Link side, clocked by TCK
  tap_state_t           state_reg;
  tap_state_t           state_next;
  logic [`IR_LEN-1:0]   ir_shift_reg;
  logic [`IR_LEN-1:0]   ir_reg;
  logic                 bypass_reg;
  logic [`ID_LEN-1:0]   id_shift_reg;
  logic [`BS_LEN-1:0]   bs_shift_reg;
  logic [`BS_LEN-1:0]   bs_capture;
  logic [`BS_PINS-1:0]  test_out_reg;
  logic [`BS_PINS-1:0]  test_oe_reg;
  logic                 extest_reg;
  logic                 tdo_reg;
  logic                 tdo_oe_reg;
  logic [3*`BS_PINS-1:0] pin_s1_reg;
  logic [3*`BS_PINS-1:0] pin_s2_reg;
  pin_drive_t           xfer_reg;
  logic                 req_tgl_reg;
  logic                 ack_s1_reg;
  logic                 ack_s2_reg;

  // Core side, clocked by clk_i
  logic                 req_s1_reg;
  logic                 req_s2_reg;
  logic                 ack_tgl_reg;
  pin_drive_t           fifo_data;
  logic                 fifo_valid;
  logic                 fifo_ready;
  logic                 fifo_in_ready;
  pin_drive_t           upd_data_reg;
  logic                 upd_valid_reg;

  // Decoded controls
  wire logic cap_dr   = (state_reg == ST_CAP_DR);
  wire logic shift_dr = (state_reg == ST_SHIFT_DR);
  wire logic upd_dr   = (state_reg == ST_UPD_DR);
  wire logic cap_ir   = (state_reg == ST_CAP_IR);
  wire logic shift_ir = (state_reg == ST_SHIFT_IR);
  wire logic upd_ir   = (state_reg == ST_UPD_IR);
  wire logic sel_id   = (ir_reg == `INS_IDCODE);
  wire logic sel_bs   = (ir_reg == `INS_EXTEST) || (ir_reg == `INS_SAMPLE);
  wire logic sel_byp  = !sel_id && !sel_bs;
  wire logic dr_tdo   = sel_id ? id_shift_reg[0] :
                        sel_bs ? bs_shift_reg[0] : bypass_reg;
  wire logic xfer_busy = (req_tgl_reg != ack_s2_reg);
  wire logic post_upd  = upd_dr && sel_bs && !xfer_busy;
  wire logic [`IR_LEN-1:0] ir_next = upd_ir ? ir_shift_reg : ir_reg;
  wire logic extest_next = (state_reg != ST_RESET) && (state_next != ST_RESET) &&
                           (ir_next == `INS_EXTEST);

  // Transition graph
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET:    state_next = tms_i ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_next = tms_i ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_next = tms_i ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_next = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = tms_i ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = tms_i ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_next = tms_i ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_next = tms_i ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_next = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = tms_i ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = tms_i ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_next = tms_i ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  // State register, asynchronous test reset
  always_ff @(posedge tck_i or negedge trst_n_i)
  begin
    if (!trst_n_i)
      state_reg <= ST_RESET;
    else
      state_reg <= state_next;
  end

  // Pin samples into the TCK domain
  always_ff @(posedge tck_i)
  begin
    pin_s1_reg <= {core_oe_i, core_out_i, pin_in_i};
    pin_s2_reg <= pin_s1_reg;
  end

  // Capture values, three cells per pin
  genvar p;
  generate
    for (p = 0; p < `BS_PINS; p++)
    begin : g_cell
      assign bs_capture[3*p+`CELL_IN]  = pin_s2_reg[p];
      assign bs_capture[3*p+`CELL_OUT] = pin_s2_reg[`BS_PINS+p];
      assign bs_capture[3*p+`CELL_OE]  = pin_s2_reg[2*`BS_PINS+p];
    end
  endgenerate

  // Instruction register
  always_ff @(posedge tck_i or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      ir_shift_reg <= `IR_CAPTURE;
      ir_reg       <= `INS_IDCODE;
    end
    else if (state_reg == ST_RESET)
      ir_reg <= `INS_IDCODE;
    else if (cap_ir)
      ir_shift_reg <= `IR_CAPTURE;
    else if (shift_ir)
      ir_shift_reg <= {tdi_i, ir_shift_reg[`IR_LEN-1:1]};
    else if (upd_ir)
      ir_reg <= ir_shift_reg;
  end

  // Data registers: only the selected one moves
  always_ff @(posedge tck_i)
  begin
    if (cap_dr && sel_byp)
      bypass_reg <= 1'b0;
    else if (shift_dr && sel_byp)
      bypass_reg <= tdi_i;
    if (cap_dr && sel_id)
      id_shift_reg <= ID_WORD;
    else if (shift_dr && sel_id)
      id_shift_reg <= {tdi_i, id_shift_reg[`ID_LEN-1:1]};
    if (cap_dr && sel_bs)
      bs_shift_reg <= bs_capture;
    else if (shift_dr && sel_bs)
      bs_shift_reg <= {tdi_i, bs_shift_reg[`BS_LEN-1:1]};
  end

  // Parallel outputs of the scan cells
  always_ff @(posedge tck_i or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      test_out_reg <= '0;
      test_oe_reg  <= '0;
      extest_reg   <= 1'b0;
    end
    else
    begin
      extest_reg <= extest_next;
      if (state_reg == ST_RESET)
        test_oe_reg <= '0;
      else if (upd_dr && sel_bs)
        for (int i = 0; i < `BS_PINS; i++)
        begin
          test_out_reg[i] <= bs_shift_reg[3*i+`CELL_OUT];
          test_oe_reg[i]  <= bs_shift_reg[3*i+`CELL_OE];
        end
    end
  end

  // Serial output changes on falling TCK
  always_ff @(negedge tck_i or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else
    begin
      tdo_reg    <= shift_ir ? ir_shift_reg[0] : dr_tdo;
      tdo_oe_reg <= shift_ir || shift_dr;
    end
  end

  // Post scan updates to the core by toggle handshake; an update made while a transfer is pending is dropped
  always_ff @(posedge tck_i or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      req_tgl_reg <= 1'b0;
      xfer_reg    <= '0;
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
    end
    else
    begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      if (post_upd)
      begin
        req_tgl_reg <= !req_tgl_reg;
        for (int i = 0; i < `BS_PINS; i++)
        begin
          xfer_reg.out[i] <= bs_shift_reg[3*i+`CELL_OUT];
          xfer_reg.oe[i]  <= bs_shift_reg[3*i+`CELL_OE];
        end
      end
    end
  end

  // Core side: accept word once the FIFO has room
  wire logic req_new = (req_s2_reg != ack_tgl_reg);
  wire logic push    = req_new && fifo_in_ready;
  wire logic out_load = !upd_valid_reg || upd_ready_i;
  assign fifo_ready = out_load;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_s1_reg    <= 1'b0;
      req_s2_reg    <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      upd_valid_reg <= 1'b0;
      upd_data_reg  <= '0;
    end
    else
    begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      if (push)
        ack_tgl_reg <= req_s2_reg;
      if (out_load)
      begin
        upd_valid_reg <= fifo_valid;
        upd_data_reg  <= fifo_data;
      end
    end
  end

  scan_fifo #(
    .WIDTH ($bits(pin_drive_t)),
    .DEPTH (`STREAM_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (xfer_reg),
    .in_valid_i  (req_new),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  assign tdo_o       = tdo_reg;
  assign tdo_oe_o    = tdo_oe_reg;
  assign test_out_o  = test_out_reg;
  assign test_oe_o   = test_oe_reg;
  assign extest_o    = extest_reg;
  assign tap_state_o = state_reg;
  assign upd_data_o  = upd_data_reg;
  assign upd_valid_o = upd_valid_reg;

endmodule : boundary_scan_tap

`default_nettype wire

// ---- verification/tap_tester.sv ----
// Tester model that drives the serial test pins
`timescale 1ns/1ps
`default_nettype none
module tap_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  input  wire logic tdo_i
);
  initial
  begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b0;
    trst_n_o = 1'b1;
    // Power-on test reset, a real falling edge
    #1 trst_n_o = 1'b0;
    #20 trst_n_o = 1'b1;
  end
  // Test reset pulse with tck standing still
  task automatic pulse_reset;
    trst_n_o = 1'b0;
    #20 trst_n_o = 1'b1;
    #20;
  endtask : pulse_reset
  // One tck period; tdi inverted once its hold is over
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #16 tck_o = 1'b1;
    q = tdo_i;
    #8 tdi_o = ~d;
    #8 tck_o = 1'b0;
  endtask : step
  // Shift n bits lsb first, then update and idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : tap_tester
`default_nettype wire

// ---- verification/boundary_scan_tap_properties.sv ----
// Concurrent checks on the test port and update stream
`timescale 1ns/1ps
`default_nettype none
`include "tap_defs.svh"
module boundary_scan_tap_properties
  import tap_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                tck_i,
  input wire logic                trst_n_i,
  input wire logic                tms_i,
  input wire logic                tdo_oe_o,
  input wire logic                extest_o,
  input wire logic [3:0]          tap_state_o,
  input wire logic [`BS_PINS-1:0] test_oe_o,
  input wire pin_drive_t          upd_data_o,
  input wire logic                upd_valid_o,
  input wire logic                upd_ready_i
);
  sequence s_tms_held;
    tms_i [*5];
  endsequence
  sequence s_enter_shift;
    tap_state_o == 4'h3 && !tms_i;
  endsequence
  a_five_ones: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    s_tms_held |=> tap_state_o == 4'h0) else $error("five tms highs missed reset");
  a_trst_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    !trst_n_i |-> tap_state_o == 4'h0 && !tdo_oe_o) else $error("test reset ignored");
  a_reset_idle: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_state_o == 4'h0 && !tms_i |=> tap_state_o == 4'h1) else $error("no idle entry");
  a_shift_steer: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_state_o == 4'h4 |=> tap_state_o == ($past(tms_i) ? 4'h5 : 4'h4))
    else $error("shift state misrouted");
  a_capture_shift: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    s_enter_shift |=> tap_state_o == 4'h4) else $error("capture not followed by shift");
  a_oe_in_shift: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tdo_oe_o == (tap_state_o == 4'h4 || tap_state_o == 4'hb)) else $error("tdo enable wrong");
  a_upd_ir_idle: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_state_o == 4'hf && !tms_i |=> tap_state_o == 4'h1) else $error("update ir misrouted");
  a_reset_quiet: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    tap_state_o == 4'h0 |=> !extest_o && test_oe_o == '0) else $error("pins driven in reset");
  a_word_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    upd_valid_o && !upd_ready_i |=> upd_valid_o && $stable(upd_data_o))
    else $error("stream word dropped");
endmodule : boundary_scan_tap_properties
bind boundary_scan_tap boundary_scan_tap_properties i_props (.clk_i, .rst_i, .tck_i,
  .trst_n_i, .tms_i, .tdo_oe_o, .extest_o, .tap_state_o, .test_oe_o, .upd_data_o,
  .upd_valid_o, .upd_ready_i);
`default_nettype wire

// ---- verification/boundary_scan_tap_tb.sv ----
// Self-checking bench for the boundary scan test port
`timescale 1ns/1ps
`default_nettype none
`include "tap_defs.svh"
module boundary_scan_tap_tb;
  import tap_pkg::*;
  logic       clk_i       = 1'b0;
  logic       rst_i       = 1'b1;
  logic       upd_ready_i = 1'b0;
  logic [7:0] pin_in_i    = 8'h00;
  logic [7:0] core_out_i  = 8'h00;
  logic [7:0] core_oe_i   = 8'h00;
  logic       tck_i, tms_i, tdi_i, trst_n_i, tdo_o, tdo_oe_o, extest_o, upd_valid_o;
  logic [7:0] test_out_o, test_oe_o;
  logic [3:0] tap_state_o;
  pin_drive_t upd_data_o;
  int         err_count = 0, samples_checked = 0, cycles = 0;

  boundary_scan_tap i_dut (.clk_i, .rst_i, .tck_i, .trst_n_i, .tms_i, .tdi_i, .tdo_o,
    .tdo_oe_o, .pin_in_i, .core_out_i, .core_oe_i, .test_out_o, .test_oe_o, .extest_o,
    .tap_state_o, .upd_data_o, .upd_valid_o, .upd_ready_i);
  tap_tester i_tester (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trst_n_o(trst_n_i),
    .tdo_i(tdo_o));

  initial forever #2.5 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Scan chain image: three cells per pin
  function automatic logic [31:0] chain(input logic [7:0] a, b, c);
    chain = '0;
    for (int p = 0; p < `BS_PINS; p++)
      chain[3*p +: 3] = {c[p], b[p], a[p]};
  endfunction : chain

  task automatic t_idcode;
    logic [31:0] q;
    i_tester.pulse_reset();
    check(tap_state_o, 4'h0);
    i_tester.scan(1'b0, 32'h0, 32, q);
    check(q, {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
    $display("test idcode done");
  endtask : t_idcode

  task automatic t_bypass;
    logic [31:0] q;
    for (int k = 0; k < 2; k++)
    begin
      i_tester.scan(1'b1, k ? {28'h0, `INS_BYPASS} : 32'h5, 4, q);
      check(q, `IR_CAPTURE);
      i_tester.scan(1'b0, 32'hb6, 8, q);
      check(q, 32'h6c);
    end
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_extest;
    logic [31:0] q;
    @(negedge clk_i);
    pin_in_i   = 8'ha5;
    core_out_i = 8'h3c;
    core_oe_i  = 8'hf0;
    i_tester.scan(1'b1, {28'h0, `INS_SAMPLE}, 4, q);
    i_tester.scan(1'b0, chain(8'h00, 8'h5a, 8'hc3), 24, q);
    check(q, chain(8'ha5, 8'h3c, 8'hf0));
    i_tester.scan(1'b1, {28'h0, `INS_EXTEST}, 4, q);
    check(extest_o, 1'b1);
    i_tester.scan(1'b0, chain(8'h00, 8'h96, 8'h0f), 24, q);
    check({test_oe_o, test_out_o}, 16'h0f96);
    $display("test extest done");
  endtask : t_extest

  task automatic t_five;
    logic q;
    i_tester.step(1'b1, 1'b0, q);
    i_tester.step(1'b0, 1'b0, q);
    i_tester.step(1'b0, 1'b0, q);
    check(tap_state_o, 4'h4);
    repeat (4) i_tester.step(1'b1, 1'b0, q);
    check(tap_state_o, 4'h9);
    i_tester.step(1'b1, 1'b0, q);
    check(tap_state_o, 4'h0);
    $display("test five ones done");
  endtask : t_five

  task automatic t_stream;
    logic [31:0] q;
    logic        b;
    logic [4:0]  walk;
    int          n;
    walk = 5'b01101;
    n = 0;
    @(negedge clk_i);
    upd_ready_i = 1'b0;
    i_tester.scan(1'b1, {28'h0, `INS_SAMPLE}, 4, q);
    i_tester.scan(1'b0, chain(8'h00, 8'h11, 8'h22), 24, q);
    repeat (35)
      for (int k = 0; k < 5; k++)
        i_tester.step(walk[k], 1'b0, b);
    repeat (20) @(negedge clk_i);
    check({upd_valid_o, upd_data_o}, 17'h12211);
    repeat (150)
    begin
      @(negedge clk_i);
      n += (upd_valid_o === 1'b1);
      upd_ready_i = 1'b1;
    end
    check(n, `STREAM_DEPTH + 3);
    check(upd_valid_o, 1'b0);
    $display("test stream done");
  endtask : t_stream

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    upd_ready_i = 1'b1;
    t_idcode();
    t_bypass();
    t_extest();
    t_five();
    t_stream();
    tally_and_finish();
  end
endmodule : boundary_scan_tap_tb
`default_nettype wire
